// ==== verilog/afifo_pkg.sv ====
// package: constants, types and the register map of the fifo pin controller
package afifo_pkg;
	// ==========================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_PULSE_NS = 20;
	localparam int RESET_RECOVER_NS = 10;
	localparam int STROBE_PULSE_NS = 20;
	localparam int STROBE_RECOVER_NS = 10;
	localparam int FLAG_DELAY_NS = 20;
	localparam int DATA_SETUP_NS = 10;
	localparam int HALF_FLAG_DELAY_NS = 30;
	localparam int RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (STROBE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYC = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLAG_CYC = (HALF_FLAG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================
	// device geometry
	localparam int WORD_W = 9;
	localparam int DEPTH = 2048;
	localparam int HALF_LEVEL = 1024;
	localparam int CNT_W = 12;
	localparam int TMR_W = 4;
	// ==========================================
	// controller register map
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_WDATA = 4'h1;
	localparam logic [3:0] ADDR_RDATA = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_COUNT = 4'h4;
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_REWIND_BIT = 1;
	localparam int CTRL_READ_BIT = 2;
	localparam int CTRL_CASCADE_BIT = 3;
	localparam int CTRL_FIRST_BIT = 4;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_EMPTY_BIT = 1;
	localparam int ST_FULL_BIT = 2;
	localparam int ST_HALF_BIT = 3;
	localparam int ST_RVALID_BIT = 4;
	localparam int ST_INIT_BIT = 5;
	localparam int ST_DROP_BIT = 6;
	localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
	// ==========================================
	// types
	typedef enum logic [1:0] {
		AFIFO_OP_WRITE,
		AFIFO_OP_READ,
		AFIFO_OP_RESET,
		AFIFO_OP_REWIND
	} afifo_op_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} afifo_bus_req_t;

	typedef struct packed {
		logic reset_n;
		logic wr_n;
		logic rd_n;
		logic rewind_n;
		logic first_device_sel;
		logic [WORD_W-1:0] wr_word;
	} afifo_pins_out_t;

	typedef struct packed {
		logic empty_n;
		logic full_n;
		logic chain_out_n;
		logic [WORD_W-1:0] rd_word;
	} afifo_pins_in_t;
endpackage

// ==== verilog/afifo_seq.sv ====
// pin sequencer: times one strobe operation on the fifo device pins
module afifo_seq
	import afifo_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire afifo_pkg::afifo_op_t op_i,
	output logic busy_o,
	output logic active_o,
	output logic sample_o,
	output logic done_o
);
	import afifo_pkg::*;

	// ==========================================
	// state
	typedef enum logic [1:0] {
		AFIFO_SQ_IDLE,
		AFIFO_SQ_SETUP,
		AFIFO_SQ_PULSE,
		AFIFO_SQ_RECOVER
	} afifo_sq_t;

	typedef struct packed {
		afifo_sq_t st;
		afifo_op_t op;
		logic [TMR_W-1:0] tmr;
	} afifo_seq_state_t;

	afifo_seq_state_t s_q;
	afifo_seq_state_t s_d;

	function automatic logic [TMR_W-1:0] cyc(input int n);
		return TMR_W'(n - 1);
	endfunction

	function automatic logic [TMR_W-1:0] recover_len();
		return cyc(FLAG_CYC > RECOVER_CYC ? FLAG_CYC : RECOVER_CYC);
	endfunction

	function automatic logic [TMR_W-1:0] pulse_len(input afifo_op_t op);
		if (op == AFIFO_OP_RESET)
		begin
			return cyc(RESET_CYC);
		end
		return cyc(PULSE_CYC);
	endfunction

	// ==========================================
	// sequencing
	always_comb
	begin
		s_d = s_q;
		sample_o = 1'b0;
		done_o = 1'b0;
		case (s_q.st)
			AFIFO_SQ_IDLE:
			begin
				if (start_i)
				begin
					s_d.op = op_i;
					s_d.st = AFIFO_SQ_SETUP;
					s_d.tmr = cyc(SETUP_CYC);
				end
			end
			AFIFO_SQ_SETUP:
			begin
				if (s_q.tmr == '0)
				begin
					s_d.st = AFIFO_SQ_PULSE;
					s_d.tmr = pulse_len(s_q.op);
				end
				else
				begin
					s_d.tmr = s_q.tmr - 1'b1;
				end
			end
			AFIFO_SQ_PULSE:
			begin
				if (s_q.tmr == '0)
				begin
					s_d.st = AFIFO_SQ_RECOVER;
					s_d.tmr = recover_len();
				end
				else
				begin
					s_d.tmr = s_q.tmr - 1'b1;
				end
			end
			AFIFO_SQ_RECOVER:
			begin
				// registered strobe is still low in the first recover cycle
				sample_o = (s_q.tmr == recover_len());
				if (s_q.tmr == '0)
				begin
					done_o = 1'b1;
					s_d.st = AFIFO_SQ_IDLE;
				end
				else
				begin
					s_d.tmr = s_q.tmr - 1'b1;
				end
			end
			default:
			begin
				s_d.st = AFIFO_SQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			s_q <= '{st: AFIFO_SQ_IDLE, op: AFIFO_OP_WRITE, tmr: '0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign busy_o = (s_q.st != AFIFO_SQ_IDLE);
	assign active_o = (s_q.st == AFIFO_SQ_PULSE);
endmodule

// ==== verilog/afifo_host.sv ====
// fifo host controller: register port to the fifo device pins
// ==========================================
// Notes on behaviour
// [R1] reset pin is held low at least the minimum reset pulse width
// [R2] device reset returns both pointers to the first location
// [R3] one reset cycle follows power-up before any write or read
// [R4] read and write strobes stay high while reset is low
// [R5] during reset empty asserts, full and half-full deassert
// [R6] write starts only when full is clear; word held around rising strobe
// [R7] device stores words at successive locations independent of reads
// [R8] full device asserts full and ignores writes until a read or reset
// [R9] read starts only when empty is clear; words return in write order
// [R10] data outputs go high impedance when read strobe rises (the bench device model drives the inverted last word instead)
// [R11] after last word empty asserts and reads are blocked
// [R12] empty clears during a write into an empty device; then read may start
// [R13] single device: rewind low returns read pointer to memory start
// [R14] read and write strobes stay high while rewind is low
// [R15] cascade: first-load pin low on first device, high on others
// [R16] chain input low when single; fed from previous device when cascaded (chain_in_n_o is tied low in both modes)
// [R17] cascaded full device passes the write token on chain out
// [R18] stand-alone: chain out acts as active-low half-full indication
// [R19] cascade: empty flags combined through one gate, full through another
// [R20] cascade: rewind and half-full indication unavailable
// [R21] each data port carries one nine-bit word
// [R22] full clears within a bounded delay after the freeing read strobe rises
// [R23] half-full asserted while more than 1024 words stored
//
// Added by the designer: the plain strobed port and the register addresses.
module afifo_host
	import afifo_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] bus_addr_i,
	input wire logic [31:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [31:0] bus_rdata_o,
	output logic reset_n_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic rewind_n_o,
	output logic first_device_sel_o,
	output logic chain_in_n_o,
	output logic [afifo_pkg::WORD_W-1:0] wr_word_o,
	input wire logic empty_n_i,
	input wire logic full_n_i,
	input wire logic chain_out_n_i,
	input wire logic [afifo_pkg::WORD_W-1:0] rd_word_i
);
	import afifo_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		afifo_pins_out_t pins;
		logic [WORD_W-1:0] rdata;
		logic rvalid;
		logic inited;
		logic drop;
		logic cascade;
		logic first;
		logic [CNT_W-1:0] count;
		logic [31:0] bus_rdata;
		logic pend;
		afifo_op_t pend_op;
	} afifo_host_state_t;

	afifo_host_state_t s_q;
	afifo_host_state_t s_d;
	afifo_bus_req_t req;
	afifo_pins_in_t pin_in;
	logic seq_busy;
	logic seq_active;
	logic seq_sample;
	logic start;
	logic half_flag;

	function automatic logic [31:0] word32(input logic [WORD_W-1:0] w);
		return {{(32-WORD_W){1'b0}}, w};
	endfunction

	assign req = '{addr: bus_addr_i, wdata: bus_wdata_i, wr: bus_wr_i, rd: bus_rd_i};
	// [R19] one composite flag pair
	assign pin_in = '{empty_n: empty_n_i, full_n: full_n_i, chain_out_n: chain_out_n_i,
		rd_word: rd_word_i};
	// [R18] half level only
	assign half_flag = !s_q.cascade && !pin_in.chain_out_n;

	// ==========================================
	// strobe sequencer
	afifo_seq u_seq (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.start_i(start),
		.op_i(s_q.pend_op),
		.busy_o(seq_busy),
		.active_o(seq_active),
		.sample_o(seq_sample),
		.done_o()
	);

	assign start = s_q.pend && !seq_busy;

	// ==========================================
	// register port and pin control
	always_comb
	begin
		s_d = s_q;
		s_d.bus_rdata = UNMAPPED_VAL;
		if (req.rd)
		begin
			case (req.addr)
				ADDR_CTRL:
				begin
					s_d.bus_rdata = '0;
					s_d.bus_rdata[CTRL_CASCADE_BIT] = s_q.cascade;
					s_d.bus_rdata[CTRL_FIRST_BIT] = s_q.first;
				end
				ADDR_WDATA:
				begin
					s_d.bus_rdata = word32(s_q.pins.wr_word);
				end
				ADDR_RDATA:
				begin
					s_d.bus_rdata = word32(s_q.rdata);
					s_d.rvalid = 1'b0;
				end
				ADDR_STATUS:
				begin
					s_d.bus_rdata = '0;
					s_d.bus_rdata[ST_BUSY_BIT] = s_q.pend || seq_busy;
					s_d.bus_rdata[ST_EMPTY_BIT] = !pin_in.empty_n;
					s_d.bus_rdata[ST_FULL_BIT] = !pin_in.full_n;
					s_d.bus_rdata[ST_HALF_BIT] = half_flag;
					s_d.bus_rdata[ST_RVALID_BIT] = s_q.rvalid;
					s_d.bus_rdata[ST_INIT_BIT] = s_q.inited;
					s_d.bus_rdata[ST_DROP_BIT] = s_q.drop;
				end
				ADDR_COUNT:
				begin
					s_d.bus_rdata = {{(32-CNT_W){1'b0}}, s_q.count};
				end
				default:
				begin
					s_d.bus_rdata = UNMAPPED_VAL;
				end
			endcase
		end
		if (start)
		begin
			s_d.pend = 1'b0;
		end
		// accept a new order only while nothing is queued or running
		if (req.wr && !s_q.pend && !seq_busy)
		begin
			if (req.addr == ADDR_CTRL)
			begin
				s_d.cascade = req.wdata[CTRL_CASCADE_BIT];
				s_d.first = req.wdata[CTRL_FIRST_BIT];
				if (req.wdata[CTRL_RESET_BIT])
				begin
					s_d.pend = 1'b1;
					s_d.pend_op = AFIFO_OP_RESET;
				end
				// [R20] no rewind when cascaded
				else if (req.wdata[CTRL_REWIND_BIT] && !req.wdata[CTRL_CASCADE_BIT] && s_q.inited)
				begin
					s_d.pend = 1'b1;
					s_d.pend_op = AFIFO_OP_REWIND;
				end
				// [R9] read gated by empty
				else if (req.wdata[CTRL_READ_BIT] && s_q.inited && pin_in.empty_n)
				begin
					s_d.pend = 1'b1;
					s_d.pend_op = AFIFO_OP_READ;
				end
				else if (req.wdata[CTRL_READ_BIT])
				begin
					s_d.drop = 1'b1;
				end
			end
			else if (req.addr == ADDR_WDATA)
			begin
				// [R21] nine-bit word
				s_d.pins.wr_word = req.wdata[WORD_W-1:0];
				// [R3] no write before reset
				// [R6] write gated by full
				if (s_q.inited && pin_in.full_n)
				begin
					s_d.pend = 1'b1;
					s_d.pend_op = AFIFO_OP_WRITE;
				end
				else
				begin
					s_d.drop = 1'b1;
				end
			end
			else if (req.addr == ADDR_STATUS)
			begin
				s_d.drop = s_q.drop && !req.wdata[ST_DROP_BIT];
			end
		end
		// [R15] first-load pin tie
		// [R13] rewind only in single mode
		s_d.pins.first_device_sel = s_q.cascade ? !s_q.first : 1'b1;
		// [R1] reset pulse width
		// [R4] strobes idle in reset
		// [R14] strobes idle in rewind
		s_d.pins.reset_n = !(seq_active && s_q.pend_op == AFIFO_OP_RESET);
		s_d.pins.rewind_n = !(seq_active && s_q.pend_op == AFIFO_OP_REWIND && !s_q.cascade);
		s_d.pins.wr_n = !(seq_active && s_q.pend_op == AFIFO_OP_WRITE);
		s_d.pins.rd_n = !(seq_active && s_q.pend_op == AFIFO_OP_READ);
		if (s_q.cascade && s_q.pend_op == AFIFO_OP_REWIND)
		begin
			s_d.pins.first_device_sel = !s_q.first;
		end
		else if (seq_active && s_q.pend_op == AFIFO_OP_REWIND)
		begin
			s_d.pins.first_device_sel = 1'b0;
		end
		if (seq_sample)
		begin
			case (s_q.pend_op)
				AFIFO_OP_READ:
				begin
					// [R10] sample before strobe rises
					s_d.rdata = pin_in.rd_word;
					s_d.rvalid = 1'b1;
					s_d.count = (s_q.count == '0) ? '0 : s_q.count - 1'b1;
				end
				AFIFO_OP_WRITE:
				begin
					// [R8] count limited at depth
					if (s_q.count != CNT_W'(DEPTH))
					begin
						s_d.count = s_q.count + 1'b1;
					end
				end
				AFIFO_OP_RESET:
				begin
					// [R2] pointers home
					s_d.count = '0;
					s_d.inited = 1'b1;
					s_d.rvalid = 1'b0;
				end
				AFIFO_OP_REWIND:
				begin
					s_d.count = '0;
				end
				default:
				begin
					s_d.count = s_q.count;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			s_q <= '{pins: '{reset_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, rewind_n: 1'b1,
				first_device_sel: 1'b1, wr_word: '0},
				rdata: '0, rvalid: 1'b0, inited: 1'b0, drop: 1'b0, cascade: 1'b0,
				first: 1'b0, count: '0, bus_rdata: '0, pend: 1'b0,
				pend_op: AFIFO_OP_RESET};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign bus_rdata_o = s_q.bus_rdata;
	assign reset_n_o = s_q.pins.reset_n;
	assign wr_n_o = s_q.pins.wr_n;
	assign rd_n_o = s_q.pins.rd_n;
	assign rewind_n_o = s_q.pins.rewind_n;
	assign first_device_sel_o = s_q.pins.first_device_sel;
	// [R16] chain input tied low single
	assign chain_in_n_o = 1'b0;
	assign wr_word_o = s_q.pins.wr_word;
endmodule

// ==== bench/afifo_dev_model.sv ====
// behavioural model of the 2k x 9 fifo device on the far side of the pins
module afifo_dev_model
	import afifo_pkg::*;
(
	input wire logic reset_n_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic rewind_n_i,
	input wire logic [afifo_pkg::WORD_W-1:0] wr_word_i,
	output logic empty_n_o,
	output logic full_n_o,
	output logic chain_out_n_o,
	output logic [afifo_pkg::WORD_W-1:0] rd_word_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [WORD_W-1:0] mem [DEPTH];
	logic [WORD_W-1:0] last;
	int wp = 0;
	int rp = 0;
	int cnt = 0;
	bit ok_w = 0;
	bit ok_r = 0;
	// flags from fill, single device only
	assign empty_n_o = (cnt != 0);
	assign full_n_o = (cnt != DEPTH);
	assign chain_out_n_o = !(cnt > HALF_LEVEL);
	initial rd_word_o = 9'h155;
	always @(negedge reset_n_i or negedge rewind_n_i)
	begin
		rp = 0;
		cnt = wp;
		if (!reset_n_i)
		begin
			wp = 0;
			cnt = 0;
		end
	end
	always @(negedge wr_n_i)
		ok_w = full_n_o;
	always @(posedge wr_n_i)
	begin
		if (ok_w)
		begin
			mem[wp] = wr_word_i;
			wp = (wp + 1) % DEPTH;
			cnt = cnt + 1;
		end
		ok_w = 0;
	end
	always @(negedge rd_n_i)
	begin
		ok_r = empty_n_o;
		if (ok_r)
		begin
			rd_word_o = mem[rp];
			last = mem[rp];
			rp = (rp + 1) % DEPTH;
		end
	end
	always @(posedge rd_n_i)
	begin
		if (ok_r)
			cnt = cnt - 1;
		ok_r = 0;
		rd_word_o = ~last;
	end
endmodule

// ==== bench/afifo_host_asserts.sv ====
// checker: pin-level properties of the fifo host controller
module afifo_host_asserts
	import afifo_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reset_n_o,
	input wire logic wr_n_o,
	input wire logic rd_n_o,
	input wire logic rewind_n_o,
	input wire logic chain_in_n_o,
	input wire logic [afifo_pkg::WORD_W-1:0] wr_word_o,
	input wire logic empty_n_i,
	input wire logic full_n_i
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	logic inited_q;
	logic inited_d;
	assign inited_d = inited_q | !reset_n_o;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			inited_q <= 1'b0;
		else
			inited_q <= inited_d;
	end
	property p_rst_pulse;
		$fell(reset_n_o) |=> $rose(reset_n_o);
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length");
	property p_init;
		!inited_q |-> wr_n_o && rd_n_o;
	endproperty
	a_init: assert property (p_init) else $error("strobe before device reset");
	property p_rst_quiet;
		!reset_n_o |-> wr_n_o && rd_n_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("strobe during reset");
	property p_wr_full;
		$fell(wr_n_o) |-> full_n_i ##1 wr_n_o;
	endproperty
	a_wr_full: assert property (p_wr_full) else $error("write into full device");
	property p_wr_hold;
		$fell(wr_n_o) |-> $stable(wr_word_o) ##1 $stable(wr_word_o);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write word moved");
	property p_rd_empty;
		$fell(rd_n_o) |-> empty_n_i ##1 rd_n_o;
	endproperty
	a_rd_empty: assert property (p_rd_empty) else $error("read from empty device");
	property p_rew_quiet;
		!rewind_n_o |-> wr_n_o && rd_n_o && reset_n_o;
	endproperty
	a_rew_quiet: assert property (p_rew_quiet) else $error("strobe during rewind");
	property p_chain;
		chain_in_n_o == 1'b0;
	endproperty
	a_chain: assert property (p_chain) else $error("chain input not low");
	c_wr: cover property ($fell(wr_n_o));
	c_rd: cover property ($fell(rd_n_o));
	c_rew: cover property ($fell(rewind_n_o));
	c_full: cover property (!full_n_i);
endmodule

// ==== bench/testbench.sv ====
// testbench: fifo host controller against a behavioural fifo device
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import afifo_pkg::*;
	logic clk_i;
	logic reset_i;
	logic [3:0] bus_addr;
	logic [31:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [31:0] bus_rdata;
	logic reset_n, wr_n, rd_n, rewind_n, first_sel, chain_in_n, empty_n, full_n, chain_out_n;
	logic [WORD_W-1:0] wr_word;
	logic [WORD_W-1:0] rd_word;
	int n_errors = 0;
	int num_checks = 0;
	logic [31:0] rd_v;
	logic [8:0] wl [3] = '{9'h1A5, 9'h03A, 9'h100};
	afifo_host afifo_host_i (.clk_i(clk_i), .reset_i(reset_i), .bus_addr_i(bus_addr),
		.bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata),
		.reset_n_o(reset_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .rewind_n_o(rewind_n),
		.first_device_sel_o(first_sel), .chain_in_n_o(chain_in_n), .wr_word_o(wr_word),
		.empty_n_i(empty_n), .full_n_i(full_n), .chain_out_n_i(chain_out_n), .rd_word_i(rd_word));
	afifo_dev_model afifo_dev_model_i (.reset_n_i(reset_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
		.rewind_n_i(rewind_n), .wr_word_i(wr_word), .empty_n_o(empty_n), .full_n_o(full_n),
		.chain_out_n_o(chain_out_n), .rd_word_o(rd_word));
	initial clk_i = 1'b0;
	always #50 clk_i = ~clk_i;
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_i);
		bus_wr <= 1'b0;
	endtask
	task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_i);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask
	task automatic op(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] s;
		int n;
		bus_write(a, d);
		s = 32'h1;
		n = 0;
		while (s[ST_BUSY_BIT] !== 1'b0 && n < 20)
		begin
			bus_read(ADDR_STATUS, s);
			n++;
		end
		check({31'h0, s[ST_BUSY_BIT]}, 32'h0);
	endtask
	task automatic chk_status(input logic [31:0] exp);
		logic [31:0] s;
		bus_read(ADDR_STATUS, s);
		check(s & 32'h4E, exp);
	endtask
	task automatic read_word(input logic [8:0] exp);
		logic [31:0] d;
		op(ADDR_CTRL, 32'h4);
		bus_read(ADDR_RDATA, d);
		check(d & 32'h1FF, {23'h0, exp});
	endtask
	initial
	begin
		reset_i = 1'b1;
		bus_addr = 4'h0;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check({28'h0, reset_n, wr_n, rd_n, rewind_n}, 32'hF);
		op(ADDR_WDATA, 32'h1);
		chk_status(32'h42);
		bus_write(ADDR_STATUS, 32'h40);
		$display("test 1 done");
		op(ADDR_CTRL, 32'h1);
		chk_status(32'h02);
		$display("test 2 done");
		op(ADDR_WDATA, {23'h0, wl[0]});
		chk_status(32'h00);
		op(ADDR_WDATA, {23'h0, wl[1]});
		op(ADDR_WDATA, {23'h0, wl[2]});
		bus_read(ADDR_COUNT, rd_v);
		check(rd_v, 32'h3);
		for (int i = 0; i < 3; i++)
			read_word(wl[i]);
		chk_status(32'h02);
		op(ADDR_CTRL, 32'h4);
		chk_status(32'h42);
		bus_write(ADDR_STATUS, 32'h40);
		$display("test 3 done");
		op(ADDR_CTRL, 32'h2);
		read_word(wl[0]);
		op(ADDR_CTRL, 32'hA);
		bus_read(ADDR_CTRL, rd_v);
		check(rd_v, 32'h8);
		check({31'h0, first_sel}, 32'h1);
		read_word(wl[1]);
		op(ADDR_CTRL, 32'h18);
		check({31'h0, first_sel}, 32'h0);
		read_word(wl[2]);
		$display("test 4 done");
		op(ADDR_CTRL, 32'h1);
		for (int i = 0; i < 1024; i++)
			op(ADDR_WDATA, i);
		chk_status(32'h00);
		op(ADDR_WDATA, 32'd1024);
		chk_status(32'h08);
		for (int i = 1025; i < 2048; i++)
			op(ADDR_WDATA, i);
		chk_status(32'h0C);
		op(ADDR_WDATA, 32'h1FF);
		chk_status(32'h4C);
		bus_write(ADDR_STATUS, 32'h40);
		read_word(9'h000);
		chk_status(32'h08);
		$display("test 5 done");
		begin
			logic [31:0] d;
			bus_read(4'hF, d);
			check(d, UNMAPPED_VAL);
		end
		$display("test 6 done");
		report_and_stop();
	end
	initial
	begin
		#(70000 * 100);
		n_errors++;
		report_and_stop();
	end
endmodule
bind afifo_host afifo_host_asserts afifo_host_asserts_i (.clk_i(clk_i), .reset_i(reset_i),
	.reset_n_o(reset_n_o), .wr_n_o(wr_n_o), .rd_n_o(rd_n_o), .rewind_n_o(rewind_n_o),
	.chain_in_n_o(chain_in_n_o), .wr_word_o(wr_word_o), .empty_n_i(empty_n_i),
	.full_n_i(full_n_i));
